// ---- hw/txshd_bank.sv ----
// transmit descriptor shadow registers with style decode behind an AXI4-Lite slave
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`include "txshd_regs.svh"

module txshd_bank
    import txshd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // updates from the transmit descriptor manager
    input wire logic prev_upd_valid,
    input wire logic [31:0] prev_upd_desc_addr,
    input wire logic [31:0] prev_upd_word1,
    input wire logic next_upd_valid,
    input wire logic [15:0] next_upd_buf_addr,
    // state and layout toward the fetch engine
    output logic stop_bit,
    output logic suspend_bit,
    output logic soft_reset_pulse,
    output logic [7:0] style_selector,
    output logic structure_size_flag,
    output logic init_wide,
    output logic init_burst,
    output logic desc_wide,
    output logic desc_burst
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
        $error("txshd_bank: ADDR_W must lie between 5 and 32");
    end

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic stop_q;
    logic suspend_q;
    logic soft_reset_q;
    logic [7:0] style_q;
    logic [15:0] prev_desc_addr_lo_field;
    logic [15:0] prev_desc_addr_hi_field;
    logic [11:0] prev_byte_count_field;
    logic [15:0] prev_status_field;
    logic [15:0] next_buffer_addr_lo_field;
    txshd_layout_type layout;

    // bus state
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // write decode
    logic wr_fire;
    logic [7:0] wr_ofs;
    logic wr_open;
    logic wr_ctrl;
    logic wr_style;
    logic wr_shadow;
    logic wr_mapped;
    logic [15:0] wr_lo16;
    logic rd_fire;
    logic [7:0] rd_ofs;

    // ----------------------------------------------------------------
    // bus handshakes
    // ----------------------------------------------------------------
    // address and data are taken together, once no response is pending
    assign awready = awvalid && wvalid && !bvalid_q;
    assign wready = awvalid && wvalid && !bvalid_q;
    assign wr_fire = awvalid && wvalid && !bvalid_q;
    assign arready = !rvalid_q;
    assign rd_fire = arvalid && !rvalid_q;
    assign wr_ofs = 8'(awaddr[ADDR_W-1:0]);
    assign rd_ofs = 8'(araddr[ADDR_W-1:0]);

    // the shadow bank and style are writable only while stopped or suspended
    assign wr_open = stop_q || suspend_q;
    assign wr_ctrl = wr_ofs == `TXSHD_OFS_CTRL;
    assign wr_style = wr_ofs == `TXSHD_OFS_STYLE;
    assign wr_shadow = wr_ofs == `TXSHD_OFS_PREV_ADDR_LO || wr_ofs == `TXSHD_OFS_PREV_ADDR_HI
        || wr_ofs == `TXSHD_OFS_PREV_DESCRIPTOR_BYTE_COUNT || wr_ofs == `TXSHD_OFS_PREV_STAT
        || wr_ofs == `TXSHD_OFS_NEXT_BUF_LO;
    assign wr_mapped = wr_ctrl || wr_style || wr_shadow;

    // reserved upper half is dropped; only byte lanes 0 and 1 matter
    assign wr_lo16 = wdata[15:0];

    // ----------------------------------------------------------------
    // control register: stop, suspend, soft reset
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_q <= `TXSHD_STOP_RESET;
            suspend_q <= 1'b0;
            soft_reset_q <= 1'b0;
        end else begin
            soft_reset_q <= 1'b0;
            if (wr_fire && wr_ctrl && wstrb[0]) begin
                stop_q <= wdata[`TXSHD_CTRL_STOP_BIT];
                suspend_q <= wdata[`TXSHD_CTRL_SUSPEND_BIT];
                soft_reset_q <= wdata[`TXSHD_CTRL_SOFT_RESET_BIT];
            end
            // software reset stops the controller
            if (soft_reset_q) begin
                stop_q <= 1'b1;
                suspend_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // style selector: cleared only by hardware reset
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            style_q <= `TXSHD_STYLE_RESET;
        end else if (wr_fire && wr_style && wr_open && wstrb[0]) begin
            style_q <= wdata[`TXSHD_STYLE_MSB:0];
        end
    end

    // ----------------------------------------------------------------
    // style decode into structure layout
    // ----------------------------------------------------------------
    always_comb begin
        layout = '0;
        unique case (style_q)
            TXSHD_STYLE_LEGACY16: begin
                layout.init_burst = 1'b1;
            end
            TXSHD_STYLE_WIDE32: begin
                layout.init_wide = 1'b1;
                layout.init_burst = 1'b1;
                layout.desc_wide = 1'b1;
                layout.size_flag = 1'b1;
            end
            TXSHD_STYLE_WIDE32_BURST: begin
                layout.init_wide = 1'b1;
                layout.init_burst = 1'b1;
                layout.desc_wide = 1'b1;
                layout.desc_burst = 1'b1;
                layout.size_flag = 1'b1;
            end
            TXSHD_STYLE_RESERVED1: begin
                layout.size_flag = 1'b1; // flag set, layout left at the safe default
            end
            default: begin
                layout = '0; // unlisted codes clear every layout bit, init_burst included, unlike the legacy layout
            end
        endcase
    end

    // ----------------------------------------------------------------
    // previous descriptor shadows: no reset term at all
    // ----------------------------------------------------------------
    // the descriptor manager wins over a software write in the same cycle
    always_ff @(posedge aclk) begin
        if (prev_upd_valid) begin
            prev_desc_addr_lo_field <= prev_upd_desc_addr[15:0];
            prev_desc_addr_hi_field <= prev_upd_desc_addr[31:16];
        end else if (wr_fire && wr_open) begin
            if (wr_ofs == `TXSHD_OFS_PREV_ADDR_LO) begin
                if (wstrb[0]) prev_desc_addr_lo_field[7:0] <= wr_lo16[7:0];
                if (wstrb[1]) prev_desc_addr_lo_field[15:8] <= wr_lo16[15:8];
            end
            if (wr_ofs == `TXSHD_OFS_PREV_ADDR_HI) begin
                if (wstrb[0]) prev_desc_addr_hi_field[7:0] <= wr_lo16[7:0];
                if (wstrb[1]) prev_desc_addr_hi_field[15:8] <= wr_lo16[15:8];
            end
        end
    end

    // byte count and status copies of descriptor word one
    always_ff @(posedge aclk) begin
        if (prev_upd_valid) begin
            prev_byte_count_field <= prev_upd_word1[`TXSHD_DESCRIPTOR_BYTE_COUNT_MSB:0];
            prev_status_field <= prev_upd_word1[31:`TXSHD_WORD1_STAT_LSB];
        end else if (wr_fire && wr_open) begin
            if (wr_ofs == `TXSHD_OFS_PREV_DESCRIPTOR_BYTE_COUNT) begin
                if (wstrb[0]) prev_byte_count_field[7:0] <= wr_lo16[7:0];
                if (wstrb[1]) prev_byte_count_field[11:8] <= wr_lo16[11:8];
            end
            if (wr_ofs == `TXSHD_OFS_PREV_STAT) begin
                if (wstrb[0]) prev_status_field[7:0] <= wr_lo16[7:0];
                if (wstrb[1]) prev_status_field[15:8] <= wr_lo16[15:8];
            end
        end
    end

    // next transmit buffer address, low half
    always_ff @(posedge aclk) begin
        if (next_upd_valid) begin
            next_buffer_addr_lo_field <= next_upd_buf_addr;
        end else if (wr_fire && wr_open && wr_ofs == `TXSHD_OFS_NEXT_BUF_LO) begin
            if (wstrb[0]) next_buffer_addr_lo_field[7:0] <= wr_lo16[7:0];
            if (wstrb[1]) next_buffer_addr_lo_field[15:8] <= wr_lo16[15:8];
        end
    end

    // ----------------------------------------------------------------
    // write response
    // ----------------------------------------------------------------
    // a locked write is dropped and answered with a slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `TXSHD_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            if (!wr_mapped) begin
                bresp_q <= `TXSHD_RESP_DECERR;
            end else if ((wr_style || wr_shadow) && !wr_open) begin
                bresp_q <= `TXSHD_RESP_SLVERR;
            end else begin
                bresp_q <= `TXSHD_RESP_OKAY;
            end
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // reserved bits read as zero; reads are allowed at any time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `TXSHD_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= '0;
            rresp_q <= `TXSHD_RESP_OKAY;
            case (rd_ofs)
                `TXSHD_OFS_CTRL: begin
                    rdata_q[`TXSHD_CTRL_STOP_BIT] <= stop_q;
                    rdata_q[`TXSHD_CTRL_SUSPEND_BIT] <= suspend_q;
                end
                `TXSHD_OFS_STYLE: begin
                    rdata_q[`TXSHD_STYLE_MSB:0] <= style_q;
                    rdata_q[`TXSHD_SIZE_FLAG_BIT] <= layout.size_flag;
                end
                `TXSHD_OFS_PREV_ADDR_LO: rdata_q[15:0] <= prev_desc_addr_lo_field;
                `TXSHD_OFS_PREV_ADDR_HI: rdata_q[15:0] <= prev_desc_addr_hi_field;
                `TXSHD_OFS_PREV_DESCRIPTOR_BYTE_COUNT: rdata_q[11:0] <= prev_byte_count_field;
                `TXSHD_OFS_PREV_STAT: rdata_q[15:0] <= prev_status_field;
                `TXSHD_OFS_NEXT_BUF_LO: rdata_q[15:0] <= next_buffer_addr_lo_field;
                default: rresp_q <= `TXSHD_RESP_DECERR;
            endcase
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign stop_bit = stop_q;
    assign suspend_bit = suspend_q;
    assign soft_reset_pulse = soft_reset_q;
    assign style_selector = style_q;
    assign structure_size_flag = layout.size_flag;
    assign init_wide = layout.init_wide;
    assign init_burst = layout.init_burst;
    assign desc_wide = layout.desc_wide;
    assign desc_burst = layout.desc_burst;

endmodule : txshd_bank

// ---- hw/txshd_regs.svh ----
// register offsets, field positions and reset values of the transmit descriptor shadow bank
//
// Function
// - style 00h: 16-bit init burst allowed, 16-bit descriptors no burst, flag 0
// - style 02h: 32-bit init and descriptors, descriptors no burst, flag 1
// - style 03h: 32-bit init and descriptors, burst allowed for both, flag 1
// - shadow registers take host writes only while stop or suspend is set
// - shadow contents survive hardware reset, software reset and stop
// - upper sixteen bits are reserved; written zero, read value free
// - previous descriptor address low half in bits 15 to 0
// - previous descriptor address high half in bits 15 to 0
// - byte count of previous descriptor word one in bits 11 to 0
// - upper half of previous descriptor word one in bits 15 to 0
// - low half of next transmit buffer address in bits 15 to 0
// - structure size flag follows the style, read only, writes ignored
// - style becomes 00h on hardware reset, kept by software reset and stop
`ifndef TXSHD_REGS_SVH
`define TXSHD_REGS_SVH

// ----------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------
`define TXSHD_OFS_CTRL 8'h00
`define TXSHD_OFS_STYLE 8'h04
`define TXSHD_OFS_PREV_ADDR_LO 8'h08
`define TXSHD_OFS_PREV_ADDR_HI 8'h0C
`define TXSHD_OFS_PREV_DESCRIPTOR_BYTE_COUNT 8'h10
`define TXSHD_OFS_PREV_STAT 8'h14
`define TXSHD_OFS_NEXT_BUF_LO 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TXSHD_CTRL_STOP_BIT 0
`define TXSHD_CTRL_SUSPEND_BIT 1
`define TXSHD_CTRL_SOFT_RESET_BIT 2
`define TXSHD_STYLE_MSB 7
`define TXSHD_SIZE_FLAG_BIT 8
`define TXSHD_FIELD_MSB 15
`define TXSHD_DESCRIPTOR_BYTE_COUNT_MSB 11
`define TXSHD_WORD1_STAT_LSB 16

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define TXSHD_STYLE_RESET 8'h00
`define TXSHD_STOP_RESET 1'b1
`define TXSHD_RESP_OKAY 2'h0
`define TXSHD_RESP_SLVERR 2'h2
`define TXSHD_RESP_DECERR 2'h3

`endif

// ---- hw/txshd_pkg.sv ----
// types shared by the transmit descriptor shadow bank
package txshd_pkg;

    // software style encodings
    typedef enum logic [7:0] {
        TXSHD_STYLE_LEGACY16 = 8'h00,
        TXSHD_STYLE_RESERVED1 = 8'h01,
        TXSHD_STYLE_WIDE32 = 8'h02,
        TXSHD_STYLE_WIDE32_BURST = 8'h03
    } txshd_style_type;

    // decoded structure layout handed to the fetch engine
    typedef struct packed {
        logic init_wide;
        logic init_burst;
        logic desc_wide;
        logic desc_burst;
        logic size_flag;
    } txshd_layout_type;

endpackage : txshd_pkg

// ---- test/txshd_checker.sv ----
// port checks for the transmit descriptor shadow bank
`include "txshd_regs.svh"

module txshd_checker #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshake
    input wire logic awvalid,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    // state and layout
    input wire logic stop_bit,
    input wire logic suspend_bit,
    input wire logic soft_reset_pulse,
    input wire logic [7:0] style_selector,
    input wire logic structure_size_flag,
    input wire logic init_wide,
    input wire logic init_burst,
    input wire logic desc_wide,
    input wire logic desc_burst
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // helper decode
    // ----------------------------------------
    logic take_w;
    logic shd_hit;
    logic open_q;
    logic [4:0] lay;
    // write taken, aimed at one of the five shadow words
    assign take_w = awvalid && wvalid && !bvalid;
    assign shd_hit = awaddr[1:0] == 2'h0 && awaddr[7:0] >= `TXSHD_OFS_PREV_ADDR_LO
        && awaddr[7:0] <= `TXSHD_OFS_NEXT_BUF_LO;
    assign open_q = stop_bit || suspend_bit;
    assign lay = {init_wide, init_burst, desc_wide, desc_burst, structure_size_flag};

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_STYLE_00: assert property (style_selector == 8'h00 |-> lay == 5'h08)
        else $error("layout wrong for style 00h");
    AST_STYLE_02: assert property (style_selector == 8'h02 |-> lay == 5'h1D)
        else $error("layout wrong for style 02h");
    AST_STYLE_03: assert property (style_selector == 8'h03 |-> lay == 5'h1F)
        else $error("layout wrong for style 03h");
    AST_SIZE_RO: assert property (structure_size_flag ==
        (style_selector inside {8'h01, 8'h02, 8'h03})) else $error("size flag off style");
    AST_LOCKED: assert property (take_w && shd_hit && !open_q
        |=> bvalid && bresp == `TXSHD_RESP_SLVERR) else $error("locked write not refused");
    AST_OPEN: assert property (take_w && shd_hit && open_q
        |=> bvalid && bresp == `TXSHD_RESP_OKAY) else $error("open write refused");
    AST_HW_STYLE: assert property ($rose(aresetn) |-> style_selector == 8'h00)
        else $error("style not 00h after reset");
    AST_SRST_KEEP: assert property (soft_reset_pulse |=> $stable(style_selector)
        && stop_bit && !suspend_bit) else $error("soft reset disturbed style");
    AST_RD_RES: assert property (rvalid |-> rdata[31:16] == 16'h0000)
        else $error("reserved read bits not zero");
    AST_RD_ANSWER: assert property (arvalid && !rvalid |=> rvalid)
        else $error("read not answered next cycle");
    // main scenarios reached
    cover property (take_w && shd_hit && !open_q);
    cover property (soft_reset_pulse);
    cover property (style_selector == 8'h03 && structure_size_flag);
endmodule : txshd_checker

bind txshd_bank txshd_checker #(.ADDR_W(ADDR_W)) u_txshd_checker (.*);

// ---- test/txshd_mgr_model.sv ----
// descriptor manager model that pushes shadow updates into the bank
module txshd_mgr_model (
    // clock
    input wire logic aclk,
    // update outputs
    output logic prev_upd_valid,
    output logic [31:0] prev_upd_desc_addr,
    output logic [31:0] prev_upd_word1,
    output logic next_upd_valid,
    output logic [15:0] next_upd_buf_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle at time zero
    initial begin
        prev_upd_valid = 1'b0;
        prev_upd_desc_addr = 32'h0;
        prev_upd_word1 = 32'h0;
        next_upd_valid = 1'b0;
        next_upd_buf_addr = 16'h0;
    end
    // finished descriptor: one-cycle pulse after gap cycles, buses scrambled after
    task automatic push_prev(input logic [31:0] addr, input logic [31:0] word1, input int gap);
        repeat (gap + 1) @(posedge aclk);
        prev_upd_valid <= 1'b1;
        prev_upd_desc_addr <= addr;
        prev_upd_word1 <= word1; // count in 11:0, status in 31:16
        @(posedge aclk);
        prev_upd_valid <= 1'b0;
        prev_upd_desc_addr <= ~addr;
        prev_upd_word1 <= ~word1;
    endtask : push_prev
    // next buffer pointer: one-cycle pulse after gap cycles
    task automatic push_next(input logic [15:0] addr, input int gap);
        repeat (gap + 1) @(posedge aclk);
        next_upd_valid <= 1'b1;
        next_upd_buf_addr <= addr;
        @(posedge aclk);
        next_upd_valid <= 1'b0;
        next_upd_buf_addr <= ~addr;
    endtask : push_next
endmodule : txshd_mgr_model

// ---- test/tb.sv ----
// self-checking bench for the transmit descriptor shadow bank
`include "txshd_regs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, pda, pw1;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, stop_bit, suspend_bit, srst;
    logic pv, nv, sz, iw, ib, dw, db;
    logic [7:0] style;
    logic [15:0] nba;
    int errors = 0;
    int checked = 0;
    logic [7:0] ofs [5] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] shd [5];
    // listed styles and their expected {init_wide, init_burst, desc_wide, desc_burst, flag}
    logic [7:0] sty [3] = '{8'h00, 8'h02, 8'h03};
    logic [4:0] lay [3] = '{5'h08, 5'h1D, 5'h1F};

    // 250 MHz clock
    always #2 aclk = ~aclk;

    txshd_bank DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .prev_upd_valid(pv), .prev_upd_desc_addr(pda),
        .prev_upd_word1(pw1), .next_upd_valid(nv), .next_upd_buf_addr(nba),
        .stop_bit(stop_bit), .suspend_bit(suspend_bit), .soft_reset_pulse(srst),
        .style_selector(style), .structure_size_flag(sz), .init_wide(iw), .init_burst(ib),
        .desc_wide(dw), .desc_burst(db));

    txshd_mgr_model mgr (.aclk(aclk), .prev_upd_valid(pv), .prev_upd_desc_addr(pda),
        .prev_upd_word1(pw1), .next_upd_valid(nv), .next_upd_buf_addr(nba));

    // ----------------------------------------
    // verdict, compare and bus tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic bound(input int n);
        if (n >= 50) begin
            errors++;
            $display("[ERR] %0t handshake timeout", $time);
            tally_and_finish();
        end
    endtask : bound
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (awready !== 1'b1 && n < 50);
        chk_word({31'h0, wready}, 32'h1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bound(n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        bound(n);
        chk_word({30'h0, bresp}, {30'h0, r});
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (arready !== 1'b1 && n < 50);
        arvalid <= 1'b0;
        bound(n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        bound(n);
        chk_word(rdata, e);
        chk_word({30'h0, rresp}, {30'h0, r});
    endtask : axi_read
    task automatic read_shadows();
        for (int i = 0; i < 5; i++) begin
            axi_read(ofs[i], shd[i], `TXSHD_RESP_OKAY);
        end
    endtask : read_shadows

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`TXSHD_OFS_STYLE, 32'h0, 2'h0);
        axi_read(`TXSHD_OFS_CTRL, 32'h1, 2'h0);
        // every listed style, with the read-only flag bit written high
        for (int i = 0; i < 3; i++) begin
            axi_write(`TXSHD_OFS_STYLE, {24'h1, sty[i]}, 2'h0);
            axi_read(`TXSHD_OFS_STYLE, {23'h0, lay[i][0], sty[i]}, 2'h0);
            chk_word({27'h0, iw, ib, dw, db, sz}, {27'h0, lay[i]});
        end
        // stopped: all shadows writable, byte count keeps 12 bits
        for (int i = 0; i < 5; i++) begin
            shd[i] = (i == 2) ? 32'h0EE2 : 32'hBEE0 + i;
            axi_write(ofs[i], 32'hBEE0 + i, 2'h0);
        end
        read_shadows();
        // running: shadow and style writes refused, contents kept
        axi_write(`TXSHD_OFS_CTRL, 32'h0, 2'h0);
        for (int i = 0; i < 5; i++) begin
            axi_write(ofs[i], 32'h1111, `TXSHD_RESP_SLVERR);
        end
        axi_write(`TXSHD_OFS_STYLE, 32'h0, `TXSHD_RESP_SLVERR);
        read_shadows();
        // manager updates, one prompt and one slow
        mgr.push_prev(32'h89AB4567, 32'hC3D2F7FE, 0);
        mgr.push_next(16'h1234, 5);
        shd = '{32'h4567, 32'h89AB, 32'h07FE, 32'hC3D2, 32'h1234};
        read_shadows();
        // suspended: writable again
        axi_write(`TXSHD_OFS_CTRL, 32'h2, 2'h0);
        axi_write(ofs[0], 32'h0F0F, 2'h0);
        shd[0] = 32'h0F0F;
        // soft reset, then a hardware reset in mid-run
        axi_write(`TXSHD_OFS_CTRL, 32'h4, 2'h0);
        axi_read(`TXSHD_OFS_CTRL, 32'h1, 2'h0);
        axi_read(`TXSHD_OFS_STYLE, 32'h103, 2'h0);
        read_shadows();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`TXSHD_OFS_STYLE, 32'h0, 2'h0);
        read_shadows();
        // unmapped offset
        axi_write(8'h40, 32'h0, `TXSHD_RESP_DECERR);
        axi_read(8'h40, 32'h0, `TXSHD_RESP_DECERR);
        tally_and_finish();
    end
endmodule : tb
